// *** pkg/burst_ctrl_pkg.sv ***
// constants for the clock output burst / pseudorandom control block
// assumes a byte-wide register port with a 16-bit address
package burst_ctrl_pkg;
   // register offsets
   localparam logic [15:0] ADDR_GAP       = 16'h10d2;
   localparam logic [15:0] ADDR_REQUEST   = 16'h10d3;
   localparam logic [15:0] ADDR_ENABLE_AB = 16'h10d4;
   localparam logic [15:0] ADDR_ENABLE_C  = 16'h10d5;
   localparam logic [15:0] ADDR_RETIME    = 16'h10d6;
   localparam logic [15:0] ADDR_DRIVER_A  = 16'h10d7;
   localparam logic [15:0] ADDR_TRIG_CTRL = 16'h10e0;
   localparam logic [15:0] ADDR_STATUS    = 16'h10e1;
   // field positions
   localparam int REQ_MODE_BIT    = 6;
   localparam int RETIME_BIT      = 0;
   localparam int MUTE_BYPASS_BIT = 5;
   localparam int DRV_MODE_LSB    = 3;
   localparam int TRIG_SRC_BIT    = 0;
   localparam int TRIG_REG_BIT    = 1;
   // writable bits; everything else reads as zero
   localparam logic [7:0] MASK_REQUEST   = 8'h7f;
   localparam logic [7:0] MASK_ENABLE_C  = 8'h0f;
   localparam logic [7:0] MASK_RETIME    = 8'h01;
   localparam logic [7:0] MASK_DRIVER_A  = 8'h3f;
   localparam logic [7:0] MASK_TRIG_CTRL = 8'h03;
   localparam logic [7:0] RESET_VALUE    = 8'h00;
   // driver mode codes
   localparam logic [1:0] DRV_DIFF   = 2'h0;
   localparam logic [1:0] DRV_SE_A   = 2'h1;
   localparam logic [1:0] DRV_SE_SEP = 2'h2;
   // divider and sequence
   localparam int         DIV_RATIO_DEFAULT = 8;
   localparam int         CHANNELS          = 4;
   localparam logic [6:0] SEQ_SEED          = 7'h7f;

   typedef enum logic [1:0] {IDLE, BURST, GAP} burst_state_type;
endpackage : burst_ctrl_pkg

// *** hdl/burst_channel.sv ***
// one divider output: burst gating, pseudorandom sequence or plain clock
// assumes cycle_tick marks the last clock of each divider output cycle
`timescale 1ns/1ps
`default_nettype none
module burst_channel
   import burst_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // divider timing
   input  wire logic       cycle_tick,
   input  wire logic       phase,
   // configuration
   input  wire logic       burst_en,
   input  wire logic       seq_en,
   input  wire logic       level_mode,
   input  wire logic [5:0] burst_len,
   input  wire logic [7:0] gap_len,
   // trigger
   input  wire logic       trig_level,
   input  wire logic       trig_rise,
   // result
   output logic            gate_out_q,
   output logic            busy
);
   burst_state_type state_q;
   logic [7:0]      cnt_q;
   logic            pending_q;
   logic [6:0]      lfsr_q;
   logic [5:0]      lfsr_low;
   logic            again;
   logic            start;

   // edge mode needs a remembered edge, level mode looks at the level
   assign again = level_mode ? trig_level : pending_q;
   assign start = cycle_tick && again && (burst_len != 6'h00)
                  && ((state_q == IDLE)
                      || (state_q == BURST && cnt_q == 8'h00
                          && gap_len == 8'h00)
                      || (state_q == GAP && cnt_q == 8'h00));
   assign busy     = (state_q != IDLE);
   assign lfsr_low = lfsr_q[5:0];

   // edge memory: a new edge in the start cycle wins over the clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pending_q <= 1'b0;
      end else if (!burst_en) begin
         pending_q <= 1'b0;
      end else if (trig_rise) begin
         pending_q <= 1'b1;
      end else if (start) begin
         pending_q <= 1'b0;
      end
   end

   // burst and gap sequencer, advanced once per divider cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= IDLE;
         cnt_q   <= 8'h00;
      end else if (!burst_en) begin
         state_q <= IDLE;
         cnt_q   <= 8'h00;
      end else if (start) begin
         state_q <= BURST;
         cnt_q   <= {2'h0, burst_len} - 8'h01;
      end else if (cycle_tick) begin
         unique case (state_q)
            IDLE: begin
               cnt_q <= 8'h00;
            end
            BURST: begin
               if (cnt_q != 8'h00) begin
                  cnt_q <= cnt_q - 8'h01;
               end else if (gap_len != 8'h00) begin
                  state_q <= GAP;
                  cnt_q   <= gap_len - 8'h01;
               end else begin
                  state_q <= IDLE;
               end
            end
            GAP: begin
               if (cnt_q != 8'h00) begin
                  cnt_q <= cnt_q - 8'h01;
               end else begin
                  state_q <= IDLE;
               end
            end
         endcase
      end
   end

   // sequence generator, one bit per divider output cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lfsr_q <= SEQ_SEED;
      end else if (!seq_en) begin
         lfsr_q <= SEQ_SEED;
      end else if (cycle_tick) begin
         lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
      end
   end

   // output select; registered so mode changes never glitch the pin
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gate_out_q <= 1'b0;
      end else if (seq_en) begin
         gate_out_q <= lfsr_q[6];
      end else if (burst_en) begin
         gate_out_q <= (state_q == BURST) && phase;
      end else begin
         gate_out_q <= phase;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   chk_burst_idle_mute: assert property (
      burst_en && !seq_en && state_q == IDLE |=> !gate_out_q)
      else $error("burst output not muted while idle");
   chk_seq_shift: assert property (
      seq_en && cycle_tick |=> lfsr_q[6:1] == $past(lfsr_low))
      else $error("sequence did not advance on divider cycle");
   chk_burst_count: assert property (
      burst_en && start |=> state_q == BURST
                            && cnt_q == {2'h0, $past(burst_len)} - 8'h01)
      else $error("burst length not loaded");
   chk_gap_count: assert property (
      burst_en && cycle_tick && !start && state_q == BURST
      && cnt_q == 8'h00 && gap_len != 8'h00
      |=> state_q == GAP && cnt_q == $past(gap_len) - 8'h01)
      else $error("gap length not loaded");
   chk_edge_start: assert property (
      burst_en && !level_mode && trig_rise && state_q == IDLE
      |=> pending_q)
      else $error("trigger edge lost");
endmodule : burst_channel
`default_nettype wire

// *** hdl/clock_output_nshot_control.sv ***
// burst / pseudorandom control for the divider outputs of one channel
// assumes trigger and mute pins are asynchronous; register port is
// byte wide with read data valid one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module clock_output_nshot_control
   import burst_ctrl_pkg::*;
#(
   parameter int DIV_RATIO = DIV_RATIO_DEFAULT   // must be even and >= 8
)(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // register port
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata_q,
   // asynchronous requests from the multifunction pins
   input  wire logic        multifunction_pins_trigger,
   input  wire logic        mute_request,
   // clock outputs
   output logic             output_pair_a_p_q,
   output logic             output_pair_a_n_q,
   output logic             divider_c_true_q,
   output logic             divider_c_complement_q
);
   localparam logic [7:0] DIV_LAST = 8'(DIV_RATIO - 1);
   localparam logic [7:0] DIV_HALF = 8'(DIV_RATIO / 2);

   logic [7:0] gap_q;
   logic [7:0] request_q;
   logic [7:0] enable_ab_q;
   logic [7:0] enable_c_q;
   logic [7:0] retime_q;
   logic [7:0] driver_a_q;
   logic [7:0] trig_ctrl_q;
   logic [7:0] div_cnt_q;
   logic       phase_q;
   logic       cycle_tick;
   logic [1:0] trig_sync_q;
   logic [1:0] mute_sync_q;
   logic       trig_src;
   logic       trig_rt_q;
   logic       trig_level;
   logic       trig_prev_q;
   logic       mute_q;
   logic [7:0] en_vec;
   logic [CHANNELS-1:0] ch_out;
   logic [CHANNELS-1:0] ch_busy;
   logic [7:0] status;
   logic [1:0] drv_mode;

   // register writes; reserved bits are masked so they stay zero
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gap_q       <= RESET_VALUE;
         request_q   <= RESET_VALUE;
         enable_ab_q <= RESET_VALUE;
         enable_c_q  <= RESET_VALUE;
         retime_q    <= RESET_VALUE;
         driver_a_q  <= RESET_VALUE;
         trig_ctrl_q <= RESET_VALUE;
      end else if (wr) begin
         unique case (addr)
            ADDR_GAP:       gap_q       <= wdata;
            ADDR_REQUEST:   request_q   <= wdata & MASK_REQUEST;
            ADDR_ENABLE_AB: enable_ab_q <= wdata;
            ADDR_ENABLE_C:  enable_c_q  <= wdata & MASK_ENABLE_C;
            ADDR_RETIME:    retime_q    <= wdata & MASK_RETIME;
            ADDR_DRIVER_A:  driver_a_q  <= wdata & MASK_DRIVER_A;
            ADDR_TRIG_CTRL: trig_ctrl_q <= wdata & MASK_TRIG_CTRL;
            default: ;
         endcase
      end
   end

   // status shows the block's own state
   assign status = {2'h0, trig_level, mute_q, ch_busy};

   // read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            ADDR_GAP:       rdata_q <= gap_q;
            ADDR_REQUEST:   rdata_q <= request_q;
            ADDR_ENABLE_AB: rdata_q <= enable_ab_q;
            ADDR_ENABLE_C:  rdata_q <= enable_c_q;
            ADDR_RETIME:    rdata_q <= retime_q;
            ADDR_DRIVER_A:  rdata_q <= driver_a_q;
            ADDR_TRIG_CTRL: rdata_q <= trig_ctrl_q;
            ADDR_STATUS:    rdata_q <= status;
            default:        rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // output divider: phase high for the first half of each cycle;
   // the tick sits in the low half so gating never cuts a pulse
   assign cycle_tick = (div_cnt_q == DIV_LAST);
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_q <= 8'h00;
         phase_q   <= 1'b0;
      end else if (cycle_tick) begin
         div_cnt_q <= 8'h00;
         phase_q   <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_q + 8'h01;
         phase_q   <= (div_cnt_q + 8'h01) < DIV_HALF;
      end
   end

   // pin synchronisers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         trig_sync_q <= 2'h0;
         mute_sync_q <= 2'h0;
      end else begin
         trig_sync_q <= {trig_sync_q[0], multifunction_pins_trigger};
         mute_sync_q <= {mute_sync_q[0], mute_request};
      end
   end

   // trigger source: pin or register bit, optionally retimed to cycles
   assign trig_src   = trig_ctrl_q[TRIG_SRC_BIT] ? trig_ctrl_q[TRIG_REG_BIT]
                                                 : trig_sync_q[1];
   assign trig_level = retime_q[RETIME_BIT] ? trig_rt_q : trig_src;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         trig_rt_q   <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         if (cycle_tick) begin
            trig_rt_q <= trig_src;
         end
         trig_prev_q <= trig_level;
      end
   end

   // mute: normally taken only at a cycle boundary to avoid runts
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mute_q <= 1'b0;
      end else if (driver_a_q[MUTE_BYPASS_BIT] || cycle_tick) begin
         mute_q <= mute_sync_q[1];
      end
   end

   // per divider enables: burst at even bits, sequence at odd bits
   assign en_vec = {enable_c_q[3:0], enable_ab_q[3:0]};
   for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      burst_channel u_ch (
         .clock      (clock),
         .reset_n    (reset_n),
         .cycle_tick (cycle_tick),
         .phase      (phase_q),
         .burst_en   (en_vec[2*i]),
         .seq_en     (en_vec[2*i+1]),
         .level_mode (request_q[REQ_MODE_BIT]),
         .burst_len  (request_q[5:0]),
         .gap_len    (gap_q),
         .trig_level (trig_level),
         .trig_rise  (trig_level && !trig_prev_q),
         .gate_out_q (ch_out[i]),
         .busy       (ch_busy[i])
      );
   end
   assign divider_c_true_q       = ch_out[2];
   assign divider_c_complement_q = ch_out[3];

   // pair a driver mode; code 3 falls back to differential
   assign drv_mode = driver_a_q[DRV_MODE_LSB +: 2];
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         output_pair_a_p_q <= 1'b0;
         output_pair_a_n_q <= 1'b0;
      end else if (mute_q) begin
         output_pair_a_p_q <= 1'b0;
         output_pair_a_n_q <= 1'b0;
      end else begin
         output_pair_a_p_q <= ch_out[0];
         unique case (drv_mode)
            DRV_SE_A:   output_pair_a_n_q <= ch_out[0];
            DRV_SE_SEP: output_pair_a_n_q <= ch_out[1];
            default:    output_pair_a_n_q <= !ch_out[0];
         endcase
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   chk_reserved_read_zero: assert property (
      rd && (addr == ADDR_ENABLE_C || addr == ADDR_RETIME
             || addr == ADDR_DRIVER_A)
      |=> rdata_q[7:6] == 2'h0)
      else $error("reserved bits read non-zero");
   chk_mute_bypass_now: assert property (
      driver_a_q[MUTE_BYPASS_BIT] && mute_sync_q[1]
      |-> ##2 (!output_pair_a_p_q && !output_pair_a_n_q))
      else $error("bypassed mute not immediate");
   chk_mute_retimed: assert property (
      !driver_a_q[MUTE_BYPASS_BIT] && !cycle_tick |=> $stable(mute_q))
      else $error("retimed mute changed mid cycle");
   chk_driver_single: assert property (
      drv_mode == DRV_SE_A && !mute_q
      |=> output_pair_a_n_q == output_pair_a_p_q)
      else $error("single-ended pair differs");
   chk_driver_diff: assert property (
      drv_mode == DRV_DIFF && !mute_q
      |=> output_pair_a_n_q != output_pair_a_p_q)
      else $error("differential pair not complementary");
   chk_plain_clock: assert property (
      enable_c_q[1:0] == 2'h0 |=> divider_c_true_q == $past(phase_q))
      else $error("plain output does not follow divider");
   chk_retime_sample: assert property (
      retime_q[RETIME_BIT] && cycle_tick |=> trig_rt_q == $past(trig_src))
      else $error("retimed trigger not sampled at cycle");
endmodule : clock_output_nshot_control
`default_nettype wire

// *** test/clock_sink.sv ***
// far-side model: a receiver watching one output clock line
// assumes the line is registered on the rising edge of clock
`timescale 1ns/1ps
`default_nettype none
module clock_sink #(
   parameter int HALF = 4   // expected high time of a pulse in clocks
)(
   // clock and control
   input  wire logic clock,
   input  wire logic clear,
   // watched line
   input  wire logic line,
   // results
   output var int    edges,
   output var int    runts
);
   logic last_q;
   int   run_q;

   // count rising edges; a pulse whose start was seen must be full width
   // so that a cut pulse after a mute shows up as a runt
   always @(posedge clock) begin
      last_q <= line;
      if (clear) begin
         edges <= 0;
         runts <= 0;
         run_q <= 0;
      end else begin
         if (line && !last_q) begin
            edges <= edges + 1;
            run_q <= 1;
         end else if (line && run_q > 0) begin
            run_q <= run_q + 1;
         end else if (!line) begin
            run_q <= 0;
         end
         if (!line && last_q && run_q != 0 && run_q != HALF) begin
            runts <= runts + 1;
         end
      end
   end
endmodule : clock_sink
`default_nettype wire

// *** test/clock_output_nshot_control_test.sv ***
// self-checking bench for the burst / pseudorandom output control
// assumes the divider ratio parameter is set here to its minimum of 8
`timescale 1ns/1ps
`default_nettype none
module clock_output_nshot_control_test;
   import burst_ctrl_pkg::*;
   localparam int DIV = 8;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  rdata_q;
   logic        trig = 1'b0;
   logic        mute = 1'b0;
   logic        clear = 1'b1;
   logic        pa_p, pa_n, c_true, c_comp;
   logic        seq [2032];
   int          err_total = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          a_edges, a_runts, c_edges, c_runts, bad, diff;
   logic [15:0] map_addr [8] = '{16'h10d2, 16'h10d3, 16'h10d4, 16'h10d5,
                                 16'h10d6, 16'h10d7, 16'h10e0, 16'h10ff};
   logic [7:0]  map_mask [8] = '{8'hff, 8'h7f, 8'hff, 8'h0f,
                                 8'h01, 8'h3f, 8'h03, 8'h00};

   // clock and cycle-count ceiling
   always #2 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         test_done();
      end
   end

   clock_output_nshot_control #(.DIV_RATIO(DIV)) clock_output_nshot_control_i (
      .clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata_q(rdata_q),
      .multifunction_pins_trigger(trig), .mute_request(mute),
      .output_pair_a_p_q(pa_p), .output_pair_a_n_q(pa_n),
      .divider_c_true_q(c_true), .divider_c_complement_q(c_comp));
   clock_sink #(.HALF(DIV/2)) sink_a_i (.clock(clock), .clear(clear),
      .line(pa_p), .edges(a_edges), .runts(a_runts));
   clock_sink #(.HALF(DIV/2)) sink_c_i (.clock(clock), .clear(clear),
      .line(c_true), .edges(c_edges), .runts(c_runts));

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_count(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_count

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk_byte(rdata_q, exp);
   endtask : rd_chk

   task automatic run(input int n);
      repeat (n) @(posedge clock);
   endtask : run

   // restart the receivers' counts
   task automatic zero();
      @(posedge clock);
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
   endtask : zero

   // count cycles where pair A n differs from p (inverted when inv set)
   // or where the plain C complement line leaves the C true line
   task automatic pair_chk(input logic inv);
      bad = 0;
      repeat (40) begin
         @(posedge clock);
         #1;
         if (pa_n !== (pa_p ^ inv)) bad++;
         if (c_comp !== c_true) bad++;
      end
      chk_count(bad, 0);
   endtask : pair_chk

   // toggle mute at shifting offsets, then hold it and expect silence
   task automatic mute_case(input int settle, input logic retimed);
      zero();
      for (int k = 0; k < 8; k++) begin
         @(posedge clock);
         mute <= 1'b1;
         run(13 + k);
         mute <= 1'b0;
         run(11 + k);
      end
      mute <= 1'b1;
      run(settle);
      // only retimed muting promises that no toggle left a cut pulse
      if (retimed) begin
         chk_count(a_runts, 0);
      end
      zero();
      run(40);
      chk_count(a_edges, 0);
      rd_chk(ADDR_STATUS, 8'h10);
      mute <= 1'b0;
   endtask : mute_case

   initial begin
      run(8);
      reset_n <= 1'b1;
      // reset values, reserved bits and an unmapped place
      for (int i = 0; i < 8; i++) begin
         rd_chk(map_addr[i], 8'h00);
         wr_reg(map_addr[i], 8'hff);
         rd_chk(map_addr[i], map_mask[i]);
         wr_reg(map_addr[i], 8'h00);
      end
      // plain clocks and differential / single-ended driver modes
      run(40);
      zero();
      run(80);
      // let the receivers' counts of this edge settle
      #1;
      chk_count(c_edges, 10);
      chk_count(a_runts, 0);
      pair_chk(1'b1);
      wr_reg(ADDR_DRIVER_A, 8'h08);
      run(8);
      pair_chk(1'b0);
      // separate dividers: n follows the AA output, held muted here
      wr_reg(ADDR_DRIVER_A, 8'h10);
      wr_reg(ADDR_ENABLE_AB, 8'h04);
      run(8);
      bad = 0;
      repeat (40) begin
         @(posedge clock);
         #1;
         if (pa_n !== 1'b0) bad++;
      end
      chk_count(bad, 0);
      wr_reg(ADDR_ENABLE_AB, 8'h00);
      wr_reg(ADDR_DRIVER_A, 8'h00);
      // edge-requested bursts of 3 pulses with a gap of 4
      wr_reg(ADDR_GAP, 8'h04);
      wr_reg(ADDR_REQUEST, 8'h03);
      wr_reg(ADDR_ENABLE_C, 8'h01);
      run(24);
      zero();
      run(80);
      #1;
      chk_count(c_edges, 0);
      chk_count(a_edges, 10);
      zero();
      trig <= 1'b1;
      run(200);
      chk_count(c_edges, 3);
      chk_count(c_runts, 0);
      zero();
      run(200);
      chk_count(c_edges, 0);
      // level mode repeats every 7 divider cycles
      wr_reg(ADDR_REQUEST, 8'h43);
      run(112);
      zero();
      run(560);
      #1;
      chk_count(c_edges, 30);
      @(posedge clock);
      trig <= 1'b0;
      wr_reg(ADDR_REQUEST, 8'h03);
      run(120);
      // internal retiming, then register triggers with the pin ignored
      wr_reg(ADDR_RETIME, 8'h01);
      zero();
      trig <= 1'b1;
      run(200);
      chk_count(c_edges, 3);
      trig <= 1'b0;
      wr_reg(ADDR_RETIME, 8'h00);
      wr_reg(ADDR_TRIG_CTRL, 8'h01);
      zero();
      trig <= 1'b1;
      run(200);
      chk_count(c_edges, 0);
      wr_reg(ADDR_TRIG_CTRL, 8'h03);
      run(200);
      chk_count(c_edges, 3);
      trig <= 1'b0;
      wr_reg(ADDR_TRIG_CTRL, 8'h00);
      // sequence repeats every 127 divider cycles and is not a plain clock
      wr_reg(ADDR_ENABLE_C, 8'h02);
      run(40);
      for (int i = 0; i < 2032; i++) begin
         @(posedge clock);
         #1;
         seq[i] = c_true;
      end
      bad = 0;
      diff = 0;
      for (int i = 0; i < 1016; i++) begin
         if (seq[i] !== seq[i + 1016]) bad++;
         if (seq[i] !== seq[i + 8]) diff++;
      end
      chk_count(bad, 0);
      chk_count(diff > 0 ? 1 : 0, 1);
      wr_reg(ADDR_ENABLE_C, 8'h00);
      // retimed mute never cuts a pulse; bypassed mute acts at once
      mute_case(DIV + 8, 1'b1);
      wr_reg(ADDR_DRIVER_A, 8'h20);
      mute_case(6, 1'b0);
      test_done();
   end
endmodule : clock_output_nshot_control_test
`default_nettype wire
